// ### verilog/ies_pkg.sv
`default_nettype none
package ies_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] IES_OFF_DISC_ERR  = 8'h00;
  localparam logic [7:0] IES_OFF_REC_ERR   = 8'h04;
  localparam logic [7:0] IES_OFF_REC_STAT  = 8'h08;
  localparam logic [7:0] IES_OFF_INT_FLAGS = 8'h0c;
  localparam logic [7:0] IES_OFF_IGNORE    = 8'h10;
  localparam logic [7:0] IES_OFF_OTHER_SET = 8'h14;
  localparam logic [7:0] IES_OFF_MASTER    = 8'h18;
  // ==========================================================
  // Field widths
  localparam int IES_DISC_W = 13;
  localparam int IES_REC_W  = 11;
  localparam int IES_STAT_W = 8;
  localparam int IES_INT_W  = 11;
  localparam int IES_IGN_W  = 11;
  localparam int IES_MST_W  = 10;
  // ==========================================================
  // Status bit holding the sticky incomplete-transfer flag
  localparam int IES_ST_INC_XFER = 6;
  // ==========================================================
  // Detailed interrupt flag positions
  localparam int IES_I_REC_NB  = 0;
  localparam int IES_I_REC_OP  = 1;
  localparam int IES_I_RTC     = 2;
  localparam int IES_I_TIMER   = 3;
  localparam int IES_I_IO_NB   = 4;
  localparam int IES_I_IO_ANY  = 5;
  localparam int IES_I_IO_OTH  = 6;
  localparam int IES_I_D_UNIT  = 7;
  localparam int IES_I_D_XFER  = 8;
  localparam int IES_I_D_DISP  = 9;
  localparam int IES_I_OTHER   = 10;
  // ==========================================================
  // Ignore toggle positions
  localparam int IES_G_DISC_ERR = 0;
  localparam int IES_G_REC_ERR  = 1;
  localparam int IES_G_IO_ERR   = 2;
  localparam int IES_G_REC_INT  = 3;
  localparam int IES_G_ANY      = 4;
  localparam int IES_G_ERROR    = 5;
  localparam int IES_G_INPUT    = 6;
  localparam int IES_G_RT       = 7;
  localparam int IES_G_OTHER    = 8;
  localparam int IES_G_FILE     = 9;
  localparam int IES_G_COMP_ERR = 10;
  localparam logic [IES_IGN_W-1:0] IES_IGN_RST = 11'h000;
  // ==========================================================
  // Timing
  localparam int IES_CLK_HZ      = 10_000_000;
  localparam int IES_HANG_TIME_S = 30;
  localparam int IES_HANG_CYC    = IES_HANG_TIME_S * IES_CLK_HZ;
endpackage : ies_pkg
`default_nettype wire

// ### verilog/ies_top.sv
// What this block does
// - Flag vertical parity error on characters leaving the disc core buffer.
// - Flag horizontal check error on data read from disc memory.
// - Flag flag-track parity errors and fixed-address parity errors.
// - Flag disc write amplifier faults and writes into inhibited locations.
// - Flag format errors in second or third disc instruction word.
// - Flag disc hang-up after 30 s timeout or missing auxiliary disc.
// - Flag disc interface access to unassigned core memory location.
// - Flag character counter or data-band counter malfunction.
// - Disc master error is OR of disc errors; own ignore toggle.
// - Record device busy when off-line or sequencing last operation off.
// - Mark incomplete transfer when only part of record is moved.
// - Flag unknown record instruction or tape motion against reel limits.
// - Flag overload when output transfer exceeds device capacity.
// - Flag off-line parity or mechanical errors after processor release.
// - Flag device unavailable when addressed device off-line or inoperative.
// - Record master interrupt is not-busy OR operator interrupt.
// - Record ignore toggle blocks program interrupt but keeps indication.
// - Raise record not-busy interrupt when operation finishes.
// - Error master is interface error OR computer error interrupt.
// - Raise clock wrap interrupt and interval timer zero interrupt.
// - Either processor sets companion interrupt; gated by its ignore toggle.
// - Three disc interrupts: operation done, transfer done, display done.
// - Operator error clear resets every detail error flag.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ies_top
  import ies_pkg::*;
#(
  parameter int HANG_CYCLES = IES_HANG_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Disc interface error events
  input  wire logic        disc_vert_par_ev,
  input  wire logic        disc_horiz_ev,
  input  wire logic        disc_flag_par_ev,
  input  wire logic        disc_fix_addr_ev,
  input  wire logic        disc_mreg_ev,
  input  wire logic        disc_write_fault_ev,
  input  wire logic        disc_write_inh_ev,
  input  wire logic        disc_instr_fmt_ev,
  input  wire logic        disc_op_busy,
  input  wire logic        disc_aux_missing_ev,
  input  wire logic        disc_data_par_ev,
  input  wire logic        disc_temp_ev,
  input  wire logic        disc_slow_ev,
  input  wire logic        disc_oper_addr_ev,
  input  wire logic        disc_count_ev,
  // Disc interface completion events
  input  wire logic        disc_unit_done_ev,
  input  wire logic        disc_xfer_done_ev,
  input  wire logic        disc_display_done_ev,
  // Record device status levels
  input  wire logic        rec_operative,
  input  wire logic        rec_offline,
  input  wire logic        rec_seq_off,
  input  wire logic        rec_start_tape,
  input  wire logic        rec_end_tape,
  input  wire logic        rec_wr_inh,
  input  wire logic        rec_file_mark,
  input  wire logic        rec_released,
  // Record device events
  input  wire logic        rec_partial_xfer_ev,
  input  wire logic        rec_online_par_ev,
  input  wire logic        rec_eavesdrop_ev,
  input  wire logic        rec_online_mech_ev,
  input  wire logic        rec_mreg_ev,
  input  wire logic        rec_bad_code_ev,
  input  wire logic        rec_fwd_cmd_ev,
  input  wire logic        rec_rev_cmd_ev,
  input  wire logic        rec_overload_ev,
  input  wire logic        rec_oper_addr_ev,
  input  wire logic        rec_offline_par_ev,
  input  wire logic        rec_horiz_ev,
  input  wire logic        rec_offline_mech_ev,
  input  wire logic        rec_access_ev,
  input  wire logic        rec_op_done_ev,
  // Operator, clock, timer, I/O and companion
  input  wire logic        operator_int_ev,
  input  wire logic        operator_err_clear,
  input  wire logic        rtc_wrap_ev,
  input  wire logic        timer_zero_ev,
  input  wire logic        io_err,
  input  wire logic        io_not_busy_ev,
  input  wire logic        io_input_any_ev,
  input  wire logic        io_other_ev,
  input  wire logic        comp_err,
  input  wire logic        other_proc_set_in,
  // Indications toward the processor
  output logic             disc_master_err,
  output logic             rec_master_err,
  output logic             err_master_int,
  output logic             rec_master_int,
  output logic             prog_int_req,
  output logic             other_proc_int,
  output logic             other_proc_set_out
);

  // ==========================================================
  // Bus slave
  logic [7:0]  addr_r;
  logic        wr_pend_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        other_pulse_r;

  wire       acc_ok  = hsel && htrans[1] && hready;
  wire       wr_go   = wr_pend_r;
  wire       hit_de  = wr_go && (addr_r == IES_OFF_DISC_ERR);
  wire       hit_re  = wr_go && (addr_r == IES_OFF_REC_ERR);
  wire       hit_st  = wr_go && (addr_r == IES_OFF_REC_STAT);
  wire       hit_in  = wr_go && (addr_r == IES_OFF_INT_FLAGS);
  wire       hit_ig  = wr_go && (addr_r == IES_OFF_IGNORE);
  wire       hit_os  = wr_go && (addr_r == IES_OFF_OTHER_SET);
  wire [7:0] rd_addr = {haddr[7:2], 2'b00};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // ==========================================================
  // Flag registers
  logic [IES_DISC_W-1:0] disc_err_r;
  logic [IES_REC_W-1:0]  rec_err_r;
  logic                  inc_xfer_r;
  logic [IES_INT_W-1:0]  int_r;
  logic [IES_IGN_W-1:0]  ign_r;
  logic [IES_MST_W-1:0]  mst_r;
  logic [28:0]           hang_cnt_r;

  // ==========================================================
  // Disc hang-up watchdog
  wire hang_hit = disc_op_busy &&
                  (hang_cnt_r == 29'(HANG_CYCLES - 1));
  wire [28:0] hang_cnt_nxt =
    !disc_op_busy                      ? 29'h0000000 :
    (hang_cnt_r == 29'(HANG_CYCLES))   ? hang_cnt_r  :
                                         hang_cnt_r + 29'h0000001;

  // ==========================================================
  // Disc detail error set terms
  wire [IES_DISC_W-1:0] disc_set = {
    disc_count_ev,
    disc_oper_addr_ev,
    disc_slow_ev,
    disc_temp_ev,
    disc_data_par_ev,
    hang_hit || disc_aux_missing_ev,
    disc_instr_fmt_ev,
    disc_write_fault_ev || disc_write_inh_ev,
    disc_mreg_ev,
    disc_fix_addr_ev,
    disc_flag_par_ev,
    disc_horiz_ev,
    disc_vert_par_ev
  };

  // ==========================================================
  // Record detail error set terms
  wire rec_motion_bad = (rec_fwd_cmd_ev && rec_end_tape) ||
                        (rec_rev_cmd_ev && rec_start_tape);
  wire rec_unavail    = rec_offline || !rec_operative;

  wire [IES_REC_W-1:0] rec_set = {
    rec_access_ev && rec_unavail,
    rec_offline_mech_ev && rec_released,
    rec_horiz_ev,
    rec_offline_par_ev && rec_released,
    rec_oper_addr_ev,
    rec_overload_ev,
    rec_bad_code_ev || rec_motion_bad,
    rec_mreg_ev,
    rec_online_mech_ev,
    rec_eavesdrop_ev,
    rec_online_par_ev
  };

  // ==========================================================
  // Detailed interrupt set terms
  wire [IES_INT_W-1:0] int_set = {
    other_proc_set_in || other_pulse_r,
    disc_display_done_ev,
    disc_xfer_done_ev,
    disc_unit_done_ev,
    io_other_ev,
    io_input_any_ev,
    io_not_busy_ev,
    timer_zero_ev,
    rtc_wrap_ev,
    operator_int_ev,
    rec_op_done_ev
  };

  // ==========================================================
  // Sticky updates, set beats clear
  wire [IES_DISC_W-1:0] disc_clr =
    {IES_DISC_W{operator_err_clear}} |
    ({IES_DISC_W{hit_de}} & hwdata[IES_DISC_W-1:0]);
  wire [IES_REC_W-1:0] rec_clr =
    {IES_REC_W{operator_err_clear}} |
    ({IES_REC_W{hit_re}} & hwdata[IES_REC_W-1:0]);
  wire [IES_INT_W-1:0] int_clr =
    {IES_INT_W{hit_in}} & hwdata[IES_INT_W-1:0];

  wire [IES_DISC_W-1:0] disc_err_nxt = (disc_err_r & ~disc_clr) |
                                       disc_set;
  wire [IES_REC_W-1:0]  rec_err_nxt  = (rec_err_r & ~rec_clr) |
                                       rec_set;
  wire [IES_INT_W-1:0]  int_nxt      = (int_r & ~int_clr) |
                                       int_set;
  wire inc_xfer_nxt = (inc_xfer_r &
                       !(hit_st && hwdata[IES_ST_INC_XFER])) |
                      rec_partial_xfer_ev;
  wire [IES_IGN_W-1:0] ign_nxt = hit_ig ? hwdata[IES_IGN_W-1:0] : ign_r;

  // ==========================================================
  // Master indications
  wire m_disc_err = |disc_err_r;
  wire m_rec_err  = |rec_err_r;
  wire iface_int  = (m_disc_err && !ign_r[IES_G_DISC_ERR]) ||
                    (m_rec_err  && !ign_r[IES_G_REC_ERR]) ||
                    (io_err     && !ign_r[IES_G_IO_ERR]);
  wire comp_int   = comp_err && !ign_r[IES_G_COMP_ERR];
  wire m_error    = iface_int || comp_int;
  wire m_rec_int  = int_r[IES_I_REC_NB] ||
                    int_r[IES_I_REC_OP];
  wire m_rt       = int_r[IES_I_RTC] || int_r[IES_I_TIMER];
  wire m_file     = int_r[IES_I_D_UNIT] || int_r[IES_I_D_XFER] ||
                    int_r[IES_I_D_DISP];
  wire m_input    = int_r[IES_I_IO_NB] || int_r[IES_I_IO_ANY] ||
                    int_r[IES_I_IO_OTH];
  wire m_other    = int_r[IES_I_OTHER] && !ign_r[IES_G_OTHER];
  wire any_src    = (m_error   && !ign_r[IES_G_ERROR]) ||
                    (m_rec_int && !ign_r[IES_G_REC_INT]) ||
                    (m_rt      && !ign_r[IES_G_RT]) ||
                    (m_file    && !ign_r[IES_G_FILE]) ||
                    (m_input   && !ign_r[IES_G_INPUT]) ||
                    m_other;
  wire m_any      = any_src && !ign_r[IES_G_ANY];

  wire [IES_MST_W-1:0] mst_nxt = {
    m_any, m_input, m_file, m_rt, m_rec_int,
    m_error, iface_int, io_err, m_rec_err, m_disc_err
  };

  // Record indication kept regardless of its ignore toggle
  wire rec_online = !rec_offline;
  wire rec_busy = rec_offline || rec_seq_off;
  wire [IES_STAT_W-1:0] stat_word = {
    rec_file_mark, inc_xfer_r, rec_wr_inh, rec_end_tape,
    rec_start_tape, rec_online, rec_busy, rec_operative
  };

  assign rdata_nxt =
    (rd_addr == IES_OFF_DISC_ERR)  ? 32'(disc_err_r) :
    (rd_addr == IES_OFF_REC_ERR)   ? 32'(rec_err_r)  :
    (rd_addr == IES_OFF_REC_STAT)  ? 32'(stat_word)  :
    (rd_addr == IES_OFF_INT_FLAGS) ? 32'(int_r)      :
    (rd_addr == IES_OFF_IGNORE)    ? 32'(ign_r)      :
    (rd_addr == IES_OFF_MASTER)    ? 32'(mst_r)      :
                                     32'h00000000;

  // ==========================================================
  // Outputs
  assign disc_master_err    = mst_r[0];
  assign rec_master_err     = mst_r[1];
  assign err_master_int     = mst_r[4];
  assign rec_master_int     = mst_r[5];
  assign prog_int_req       = mst_r[9];
  assign other_proc_int     = int_r[IES_I_OTHER] && !ign_r[IES_G_OTHER];
  assign other_proc_set_out = other_pulse_r;

  // ==========================================================
  // Bus registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r        <= 8'h00;
      wr_pend_r     <= 1'b0;
      rdata_r       <= 32'h00000000;
      other_pulse_r <= 1'b0;
    end else begin
      wr_pend_r     <= acc_ok && hwrite;
      other_pulse_r <= hit_os && hwdata[0];
      if (acc_ok) begin
        addr_r <= rd_addr;
      end
      if (acc_ok && !hwrite) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // Flag registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      disc_err_r <= '0;
      rec_err_r  <= '0;
      inc_xfer_r <= 1'b0;
      int_r      <= '0;
      ign_r      <= IES_IGN_RST;
      mst_r      <= '0;
      hang_cnt_r <= 29'h0000000;
    end else begin
      disc_err_r <= disc_err_nxt;
      rec_err_r  <= rec_err_nxt;
      inc_xfer_r <= inc_xfer_nxt;
      int_r      <= int_nxt;
      ign_r      <= ign_nxt;
      mst_r      <= mst_nxt;
      hang_cnt_r <= hang_cnt_nxt;
    end
  end

endmodule : ies_top
`default_nettype wire

// ### testbench/ies_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ies_monitor #(
  parameter int HANG_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk, rstn,
  // Causes
  input wire logic disc_vert_par_ev, disc_count_ev, disc_op_busy,
  input wire logic rec_access_ev, rec_offline, rec_op_done_ev,
  input wire logic rec_offline_mech_ev, rec_released,
  input wire logic operator_int_ev, io_err, comp_err,
  // Indications
  input wire logic disc_master_err, rec_master_err, err_master_int,
  input wire logic rec_master_int, other_proc_set_out
);
  // ==========================================================
  // Run length of disc busy
  int busy_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busy_r <= 0;
    else busy_r <= disc_op_busy ? busy_r + 1 : 0;
  end
  // ==========================================================
  // Properties
  chk_disc_vert: assert property (@(posedge clk) disable iff (!rstn)
    disc_vert_par_ev |-> ##2 disc_master_err)
    else $error("disc master error missing after parity event");
  chk_disc_count: assert property (@(posedge clk) disable iff (!rstn)
    disc_count_ev |=> ##1 disc_master_err)
    else $error("disc master error missing after count event");
  chk_hang_set: assert property (@(posedge clk) disable iff (!rstn)
    busy_r == HANG_CYCLES |-> ##[0:4] disc_master_err)
    else $error("hang-up not flagged after busy timeout");
  chk_rec_unavail: assert property (@(posedge clk) disable iff (!rstn)
    rec_access_ev && rec_offline |-> ##2 rec_master_err)
    else $error("device unavailable not flagged");
  chk_rec_mech: assert property (@(posedge clk) disable iff (!rstn)
    rec_offline_mech_ev && rec_released |-> ##2 rec_master_err)
    else $error("off-line mechanical error not flagged");
  chk_rec_int_src: assert property (@(posedge clk) disable iff (!rstn)
    (rec_op_done_ev || operator_int_ev) |-> ##2 rec_master_int)
    else $error("record master interrupt missing");
  chk_err_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (!comp_err && !io_err && !disc_master_err && !rec_master_err)[*4]
    ##1 (!disc_master_err && !rec_master_err) |-> !err_master_int)
    else $error("error master set without any error source");
  chk_set_pulse: assert property (@(posedge clk) disable iff (!rstn)
    $rose(other_proc_set_out) |=> !other_proc_set_out)
    else $error("companion set pulse longer than one cycle");
endmodule : ies_monitor
bind ies_top ies_monitor #(.HANG_CYCLES(HANG_CYCLES)) u_mon (.*);
`default_nettype wire

// ### testbench/ies_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module ies_periph_model (
  // Clock
  input  wire logic        clk,
  // Event pulses and levels toward the block
  output var  logic [38:0] ev,
  output var  logic [11:0] lv
);
  initial begin
    ev = '0;
    lv = 12'h001;
  end
  // One event for one clock, released after
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask : pulse
  task levels(input logic [11:0] v);
    @(posedge clk);
    lv <= v;
  endtask : levels
endmodule : ies_periph_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ies_pkg::*;
  // ==========================================================
  // Bus, far side and indications
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [38:0] ev;
  logic [11:0] lv;
  logic hreadyout, hresp, disc_master_err, rec_master_err, err_master_int;
  logic rec_master_int, prog_int_req, other_proc_int, other_proc_set_out;
  wire logic hready = hreadyout;
  wire logic disc_vert_par_ev = ev[0], disc_horiz_ev = ev[1],
    disc_flag_par_ev = ev[2], disc_fix_addr_ev = ev[3], disc_mreg_ev = ev[4],
    disc_write_fault_ev = ev[5], disc_write_inh_ev = ev[6],
    disc_instr_fmt_ev = ev[7], disc_aux_missing_ev = ev[8],
    disc_data_par_ev = ev[9], disc_temp_ev = ev[10], disc_slow_ev = ev[11],
    disc_oper_addr_ev = ev[12], disc_count_ev = ev[13],
    disc_unit_done_ev = ev[14], disc_xfer_done_ev = ev[15],
    disc_display_done_ev = ev[16], rec_online_par_ev = ev[17],
    rec_eavesdrop_ev = ev[18], rec_online_mech_ev = ev[19],
    rec_mreg_ev = ev[20], rec_bad_code_ev = ev[21], rec_overload_ev = ev[22],
    rec_oper_addr_ev = ev[23], rec_horiz_ev = ev[24],
    rec_offline_par_ev = ev[25], rec_offline_mech_ev = ev[26],
    rec_access_ev = ev[27], rec_fwd_cmd_ev = ev[28], rec_rev_cmd_ev = ev[29],
    rec_partial_xfer_ev = ev[30], rec_op_done_ev = ev[31],
    operator_int_ev = ev[32], rtc_wrap_ev = ev[33], timer_zero_ev = ev[34],
    io_not_busy_ev = ev[35], io_input_any_ev = ev[36], io_other_ev = ev[37],
    other_proc_set_in = ev[38];
  wire logic rec_operative = lv[0], rec_offline = lv[1], rec_seq_off = lv[2],
    rec_start_tape = lv[3], rec_end_tape = lv[4], rec_wr_inh = lv[5],
    rec_file_mark = lv[6], rec_released = lv[7], disc_op_busy = lv[8],
    operator_err_clear = lv[9], io_err = lv[10], comp_err = lv[11];
  ies_top #(.HANG_CYCLES(20)) uut (.*);
  ies_periph_model pm (.clk(clk), .ev(ev), .lv(lv));
  // ==========================================================
  // Tables, counters, clock and timeout
  int disc_bit [14] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 10, 11, 12};
  int rec_ev [16] = '{17, 18, 19, 20, 21, 22, 23, 24, 28, 28, 29, 25, 25, 26,
                      27, 27};
  logic [11:0] rec_lv [16] = '{1, 1, 1, 1, 1, 1, 1, 1, 12'h001, 12'h011,
    12'h009, 12'h001, 12'h081, 12'h081, 12'h002, 12'h001};
  int rec_bit [16] = '{0, 1, 2, 3, 4, 5, 6, 8, -1, 4, 4, -1, 7, 9, 10, -1};
  int int_ev [11] = '{14, 15, 16, 31, 32, 33, 34, 35, 36, 37, 38};
  int int_bit [11] = '{7, 8, 9, 0, 1, 2, 3, 4, 5, 6, 10};
  int error_cnt = 0, samples_checked = 0, cyc = 0, pulses = 0, p0, i;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (other_proc_set_out === 1'b1) pulses <= pulses + 1;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ==========================================================
  // Scenarios
  task t_reset;
    for (i = 0; i < 8; i++) begin
      bus(0, 8'(i * 4), 0);
      chk("reset value", rd, i == 2 ? 32'h5 : 32'h0);
      chk("okay resp", 32'(hresp), 32'h0);
    end
  endtask : t_reset
  task t_disc;
    for (i = 0; i < 14; i++) begin
      pm.pulse(i);
      settle(12);
      chk("disc master", disc_master_err, 1);
      bus(0, IES_OFF_DISC_ERR, 0);
      chk("disc flags", rd, 32'h1 << disc_bit[i]);
      bus(1, IES_OFF_DISC_ERR, 32'h1fff);
      settle(2);
      chk("disc master", disc_master_err, 0);
    end
  endtask : t_disc
  task t_hang;
    pm.levels(12'h101);
    settle(10);
    pm.levels(12'h001);
    bus(0, IES_OFF_DISC_ERR, 0);
    chk("short busy", rd, 0);
    pm.levels(12'h101);
    settle(25);
    pm.levels(12'h001);
    bus(0, IES_OFF_DISC_ERR, 0);
    chk("hang flag", rd, 32'h80);
    bus(1, IES_OFF_DISC_ERR, 32'h80);
  endtask : t_hang
  task t_clear;
    pm.pulse(0);
    pm.pulse(17);
    pm.levels(12'h201);
    settle(2);
    pm.levels(12'h001);
    bus(0, IES_OFF_DISC_ERR, 0);
    chk("cleared disc", rd, 0);
    bus(0, IES_OFF_REC_ERR, 0);
    chk("cleared rec", rd, 0);
  endtask : t_clear
  task t_rec;
    for (i = 0; i < 16; i++) begin
      pm.levels(rec_lv[i]);
      pm.pulse(rec_ev[i]);
      settle(3);
      chk("rec master", rec_master_err, rec_bit[i] >= 0);
      bus(0, IES_OFF_REC_ERR, 0);
      chk("rec flags", rd, rec_bit[i] < 0 ? 0 : 32'h1 << rec_bit[i]);
      bus(1, IES_OFF_REC_ERR, 32'h7ff);
      settle(2);
    end
  endtask : t_rec
  task t_stat;
    pm.levels(12'h002);
    bus(0, IES_OFF_REC_STAT, 0);
    chk("offline stat", rd, 32'h02);
    pm.levels(12'h004);
    bus(0, IES_OFF_REC_STAT, 0);
    chk("seq off stat", rd, 32'h06);
    pm.levels(12'h079);
    bus(0, IES_OFF_REC_STAT, 0);
    chk("tape stat", rd, 32'hbd);
    pm.levels(12'h001);
    pm.pulse(30);
    settle(10);
    bus(0, IES_OFF_REC_STAT, 0);
    chk("inc xfer", rd, 32'h45);
    bus(1, IES_OFF_REC_STAT, 32'hff);
    bus(0, IES_OFF_REC_STAT, 0);
    chk("inc xfer clr", rd, 32'h05);
  endtask : t_stat
  task t_int;
    for (i = 0; i < 11; i++) begin
      pm.pulse(int_ev[i]);
      settle(3);
      chk("any int", prog_int_req, 1);
      bus(0, IES_OFF_INT_FLAGS, 0);
      chk("int flags", rd, 32'h1 << int_bit[i]);
      bus(1, IES_OFF_INT_FLAGS, 32'h7ff);
      settle(3);
      chk("any int", prog_int_req, 0);
    end
  endtask : t_int
  task t_mask;
    bus(1, IES_OFF_IGNORE, 32'h18);
    pm.pulse(32);
    settle(3);
    chk("rec int", rec_master_int, 1);
    chk("any int", prog_int_req, 0);
    bus(1, IES_OFF_IGNORE, 32'h08);
    settle(3);
    chk("any int", prog_int_req, 0);
    bus(1, IES_OFF_IGNORE, 32'h10);
    settle(3);
    chk("any int", prog_int_req, 0);
    bus(1, IES_OFF_IGNORE, 32'h0);
    settle(3);
    chk("any int", prog_int_req, 1);
    bus(1, IES_OFF_INT_FLAGS, 32'h7ff);
  endtask : t_mask
  task t_other;
    p0 = pulses;
    bus(1, IES_OFF_OTHER_SET, 32'h1);
    settle(3);
    chk("set pulses", pulses, p0 + 1);
    chk("other int", other_proc_int, 1);
    bus(1, IES_OFF_IGNORE, 32'h100);
    settle(1);
    chk("other int", other_proc_int, 0);
    bus(1, IES_OFF_IGNORE, 32'h0);
    bus(1, IES_OFF_INT_FLAGS, 32'h400);
  endtask : t_other
  task t_err;
    pm.levels(12'h401);
    settle(3);
    chk("err master", err_master_int, 1);
    bus(0, IES_OFF_MASTER, 0);
    chk("io err bit", rd & 32'h4, 32'h4);
    pm.levels(12'h801);
    settle(3);
    chk("err master", err_master_int, 1);
    bus(1, IES_OFF_IGNORE, 32'h400);
    settle(3);
    chk("err master", err_master_int, 0);
    pm.levels(12'h001);
    bus(1, IES_OFF_IGNORE, 32'h1);
    pm.pulse(0);
    settle(3);
    chk("err master", err_master_int, 0);
    bus(1, IES_OFF_IGNORE, 32'h0);
    settle(3);
    chk("err master", err_master_int, 1);
    bus(1, IES_OFF_DISC_ERR, 32'h1fff);
  endtask : t_err
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_disc();
    t_hang();
    t_clear();
    t_rec();
    t_stat();
    t_int();
    t_mask();
    t_other();
    t_err();
    results();
  end
endmodule : tb_top
`default_nettype wire
